// [rtl/dtr_params.svh]
// Constants for the debug trigger block: register numbers,
// field positions, reset values and status codes. Included by the package and the RTL modules.
`ifndef DTR_PARAMS_SVH
`define DTR_PARAMS_SVH

`define DTR_ATTR_REG_NUM 4'h6
`define DTR_TRIG_DEF_NUM 4'h7

`define DTR_ATTR_REG_RST 16'h0000
`define DTR_TRIG_DEF_RST 32'h0000_0000
`define DTR_PORT_ATTR_RST 8'h05

`define DTR_ATTR_VAL_HI 7
`define DTR_ATTR_MASK_HI 15
`define DTR_ATTR_MASK_LO 8

`define DTR_RESP_HI 31
`define DTR_RESP_LO 30
`define DTR_L2_EN_BIT 29
`define DTR_L2_LANE_HI 28
`define DTR_L2_LANE_LO 22
`define DTR_L2_COMB_BIT 15
`define DTR_L1_EN_BIT 13

`define DTR_RESP_STATUS 2'h0
`define DTR_RESP_HALT 2'h1
`define DTR_RESP_IRQ 2'h2
`define DTR_RESP_RSVD 2'h3

`define DTR_ST_IDLE 4'h0
`define DTR_ST_WAIT_L1 4'h1
`define DTR_ST_DONE_L1 4'h2
`define DTR_ST_WAIT_L2 4'h5
`define DTR_ST_DONE_L2 4'h6

`endif

// [rtl/dtr_pkg.sv]
// Types shared by the debug trigger block.
// Assumes dtr_params.svh sits on the include path.
`include "dtr_params.svh"

package dtr_pkg;

	typedef enum logic [2:0] {
		DTR_IDLE,
		DTR_WAIT_L1,
		DTR_DONE_L1,
		DTR_WAIT_L2,
		DTR_DONE_L2
	} dtr_state_e;

	typedef logic [7:0] dtr_attr_t;

endpackage

// [rtl/dtr_attr_match.sv]
// Masked comparison of the stored attribute word against live bus attributes.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`include "dtr_params.svh"

module dtr_attr_match
	import dtr_pkg::*;
(
	input wire logic [15:0] attr_in,
	input wire logic bus_valid_in,
	input wire logic bus_rw_in,
	input wire logic [1:0] bus_size_in,
	input wire logic [1:0] bus_type_in,
	input wire logic [2:0] bus_modifier_in,
	output logic match_out
);

	// Mask bits 15..8 line up one for one with value bits 7..0
	wire dtr_attr_t bus_attr;
	wire dtr_attr_t attr_value;
	wire dtr_attr_t attr_mask;
	wire dtr_attr_t miss;

	assign bus_attr = {bus_rw_in, bus_size_in, bus_type_in, bus_modifier_in};
	assign attr_value = attr_in[`DTR_ATTR_VAL_HI:0];
	assign attr_mask = attr_in[`DTR_ATTR_MASK_HI:`DTR_ATTR_MASK_LO];
	assign miss = (attr_value ^ bus_attr) & ~attr_mask;
	assign match_out = bus_valid_in && (miss == 8'h00);

endmodule

// [rtl/dtr_trigger.sv]
// Top of the debug trigger block: register writes, trigger sequencing, response.
// Assumes all inputs come from logic on core_clk_in; no pin synchronisers needed.
`timescale 1ns/1ps
`include "dtr_params.svh"

module dtr_trigger
	import dtr_pkg::*;
#(
	parameter int DREG_NUM_W = 4,
	parameter int LANES = 7
)
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic core_wr_in,
	input wire logic core_super_in,
	input wire logic [DREG_NUM_W-1:0] core_dreg_num_in,
	input wire logic [31:0] core_dreg_data_in,
	input wire logic port_wr_in,
	input wire logic [DREG_NUM_W-1:0] port_dreg_num_in,
	input wire logic [31:0] port_dreg_data_in,
	input wire logic bus_valid_in,
	input wire logic bus_rw_in,
	input wire logic [1:0] bus_size_in,
	input wire logic [1:0] bus_type_in,
	input wire logic [2:0] bus_modifier_in,
	input wire logic level_one_hit_in,
	input wire logic pc_cond_in,
	input wire logic addr_range_in,
	input wire logic [LANES-1:0] data_lane_hit_in,
	output logic attr_match_out,
	output logic [3:0] breakpoint_status_out,
	output logic trigger_report_out,
	output logic halt_req_out,
	output logic debug_irq_out,
	output logic [7:0] port_mem_attr_out
);

	logic [15:0] attribute_match_reg;
	logic [31:0] trigger_definition_reg;
	dtr_state_e state;
	dtr_state_e next_state;

	// Initial state right after a trigger definition write
	function automatic dtr_state_e arm_state(input logic [31:0] def);
		dtr_state_e s;
		s = DTR_IDLE;
		if (def[`DTR_L1_EN_BIT])
			s = DTR_WAIT_L1;
		else if (def[`DTR_L2_EN_BIT])
			s = DTR_WAIT_L2;
		return s;
	endfunction

	function automatic logic [3:0] status_of(input dtr_state_e s);
		logic [3:0] code;
		code = `DTR_ST_IDLE;
		unique case (s)
			DTR_IDLE: code = `DTR_ST_IDLE;
			DTR_WAIT_L1: code = `DTR_ST_WAIT_L1;
			DTR_DONE_L1: code = `DTR_ST_DONE_L1;
			DTR_WAIT_L2: code = `DTR_ST_WAIT_L2;
			DTR_DONE_L2: code = `DTR_ST_DONE_L2;
		endcase
		return code;
	endfunction

	// Write selection; the port wins when both sources write in one cycle
	wire core_ok;
	wire wr_en;
	wire [DREG_NUM_W-1:0] wr_num;
	wire [31:0] wr_data;
	wire attr_reg_wr;
	wire trig_def_wr;

	assign core_ok = core_wr_in && core_super_in;
	assign wr_en = port_wr_in || core_ok;
	assign wr_num = port_wr_in ? port_dreg_num_in : core_dreg_num_in;
	assign wr_data = port_wr_in ? port_dreg_data_in : core_dreg_data_in;
	assign attr_reg_wr = wr_en && (wr_num == DREG_NUM_W'(`DTR_ATTR_REG_NUM));
	assign trig_def_wr = wr_en && (wr_num == DREG_NUM_W'(`DTR_TRIG_DEF_NUM));

	// Trigger definition fields
	wire [1:0] response_sel;
	wire level_two_global_enable;
	wire level_one_global_enable;
	wire [LANES-1:0] level_two_data_lane_enable;
	wire level_two_combine_select;

	assign response_sel = trigger_definition_reg[`DTR_RESP_HI:`DTR_RESP_LO];
	assign level_two_global_enable = trigger_definition_reg[`DTR_L2_EN_BIT];
	assign level_one_global_enable = trigger_definition_reg[`DTR_L1_EN_BIT];
	assign level_two_data_lane_enable = trigger_definition_reg[`DTR_L2_LANE_HI:`DTR_L2_LANE_LO];
	assign level_two_combine_select = trigger_definition_reg[`DTR_L2_COMB_BIT];

	wire attr_hit;

	dtr_attr_match u_match (
		.attr_in(attribute_match_reg),
		.bus_valid_in(bus_valid_in),
		.bus_rw_in(bus_rw_in),
		.bus_size_in(bus_size_in),
		.bus_type_in(bus_type_in),
		.bus_modifier_in(bus_modifier_in),
		.match_out(attr_hit)
	);

	// Level two condition
	wire data_cond;
	wire addr_cond;
	wire level_two_hit;
	wire level_one_hit;

	assign data_cond = (level_two_data_lane_enable == '0) ||
		|(level_two_data_lane_enable & data_lane_hit_in);
	assign addr_cond = addr_range_in && attr_hit;
	assign level_two_hit = level_two_global_enable && (level_two_combine_select ?
		(pc_cond_in || (addr_cond && data_cond)) :
		(pc_cond_in && (addr_cond && data_cond)));
	assign level_one_hit = level_one_global_enable && level_one_hit_in;

	// Sequencing: level one arms level two when both are enabled
	always_comb
	begin
		next_state = state;
		if (trig_def_wr)
			next_state = arm_state(wr_data);
		else
		begin
			unique case (state)
				DTR_IDLE: next_state = DTR_IDLE;
				DTR_WAIT_L1:
					if (level_one_hit)
						next_state = level_two_global_enable ? DTR_WAIT_L2 : DTR_DONE_L1;
				DTR_WAIT_L2:
					if (level_two_hit)
						next_state = DTR_DONE_L2;
				DTR_DONE_L1: next_state = DTR_DONE_L1;
				DTR_DONE_L2: next_state = DTR_DONE_L2;
			endcase
		end
	end

	// A trigger completes on entry into either done state
	wire fire;

	assign fire = !trig_def_wr && (next_state != state) &&
		((next_state == DTR_DONE_L1) || (next_state == DTR_DONE_L2));

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			attribute_match_reg <= `DTR_ATTR_REG_RST;
			port_mem_attr_out <= `DTR_PORT_ATTR_RST;
		end
		else if (attr_reg_wr)
		begin
			attribute_match_reg <= wr_data[15:0];
			port_mem_attr_out <= wr_data[7:0];
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			trigger_definition_reg <= `DTR_TRIG_DEF_RST;
		else if (trig_def_wr)
			trigger_definition_reg <= wr_data;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			state <= DTR_IDLE;
			breakpoint_status_out <= `DTR_ST_IDLE;
		end
		else
		begin
			state <= next_state;
			breakpoint_status_out <= status_of(next_state);
		end
	end

	// Responses are one-cycle pulses; the reserved code only reports status
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			trigger_report_out <= 1'b0;
			halt_req_out <= 1'b0;
			debug_irq_out <= 1'b0;
			attr_match_out <= 1'b0;
		end
		else
		begin
			trigger_report_out <= fire;
			halt_req_out <= fire && (response_sel == `DTR_RESP_HALT);
			debug_irq_out <= fire && (response_sel == `DTR_RESP_IRQ);
			attr_match_out <= attr_hit;
		end
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	a_def_wr_clear: assert property (trig_def_wr |=>
		breakpoint_status_out != `DTR_ST_DONE_L1 && breakpoint_status_out != `DTR_ST_DONE_L2)
		else $error("status not cleared by trigger definition write");

	a_port_attr_load: assert property (attr_reg_wr |=>
		port_mem_attr_out == $past(wr_data[7:0]) && attribute_match_reg[7:0] == port_mem_attr_out)
		else $error("port attribute not loaded with attribute write");

	a_port_write_wins: assert property (port_wr_in && attr_reg_wr |=>
		attribute_match_reg == $past(port_dreg_data_in[15:0]))
		else $error("port attribute write not stored");

	a_core_attr_write: assert property (core_ok && !port_wr_in && attr_reg_wr |=>
		attribute_match_reg == $past(core_dreg_data_in[15:0]))
		else $error("supervisor attribute write not stored");

	a_def_store: assert property (trig_def_wr |=>
		trigger_definition_reg == $past(wr_data))
		else $error("trigger definition write not stored");

	a_arm_level_one: assert property (trig_def_wr && wr_data[`DTR_L1_EN_BIT] |=>
		breakpoint_status_out == `DTR_ST_WAIT_L1)
		else $error("level one not armed by definition write");

	a_arm_level_two: assert property (trig_def_wr && !wr_data[`DTR_L1_EN_BIT] &&
		wr_data[`DTR_L2_EN_BIT] |=> breakpoint_status_out == `DTR_ST_WAIT_L2)
		else $error("level two not armed by definition write");

	a_one_arms_two: assert property (state == DTR_WAIT_L1 && level_one_hit &&
		level_two_global_enable && !trig_def_wr |=>
		breakpoint_status_out == `DTR_ST_WAIT_L2 && !trigger_report_out)
		else $error("level one hit did not arm level two");

	a_halt_only_code: assert property (halt_req_out |->
		trigger_report_out && $past(response_sel) == `DTR_RESP_HALT && !debug_irq_out)
		else $error("halt without halt response code");

	a_irq_only_code: assert property (fire && response_sel == `DTR_RESP_IRQ && !trig_def_wr |=>
		debug_irq_out && !halt_req_out)
		else $error("debug interrupt missing for interrupt response code");

	a_report_only_code: assert property (fire && (response_sel == `DTR_RESP_STATUS ||
		response_sel == `DTR_RESP_RSVD) |=>
		trigger_report_out && !halt_req_out && !debug_irq_out)
		else $error("status-only response raised halt or interrupt");

	a_report_pulse: assert property (trigger_report_out |=> !trigger_report_out)
		else $error("trigger report lasted more than one cycle");

	a_l2_needs_enable: assert property ($rose(breakpoint_status_out == `DTR_ST_DONE_L2) |->
		$past(level_two_global_enable))
		else $error("level two fired while globally disabled");

	a_combine_or: assert property (state == DTR_WAIT_L2 && level_two_global_enable &&
		level_two_combine_select && pc_cond_in && !trig_def_wr |=>
		breakpoint_status_out == `DTR_ST_DONE_L2)
		else $error("OR combine did not fire on PC condition");

	a_all_masked_hit: assert property (bus_valid_in && attribute_match_reg[15:8] == 8'hFF |=>
		attr_match_out)
		else $error("fully masked attribute failed to match");

	a_rw_compared: assert property (bus_valid_in && !attribute_match_reg[15] &&
		bus_rw_in != attribute_match_reg[7] |=> !attr_match_out)
		else $error("read/write mismatch still matched");

	a_size_compared: assert property (bus_valid_in && attribute_match_reg[14:13] == 2'h0 &&
		bus_size_in != attribute_match_reg[6:5] |=> !attr_match_out)
		else $error("size mismatch still matched");

	a_idle_no_match: assert property (!bus_valid_in |=> !attr_match_out)
		else $error("attribute match without a bus transfer");

	a_reset_zero: assert property (disable iff (1'b0) $fell(rst_in) |->
		attribute_match_reg == `DTR_ATTR_REG_RST &&
		trigger_definition_reg == `DTR_TRIG_DEF_RST)
		else $error("registers not zero after reset");

	a_user_wr_ignored: assert property (core_wr_in && !core_super_in && !port_wr_in |=>
		$stable(trigger_definition_reg) && $stable(attribute_match_reg))
		else $error("non-supervisor write changed a register");

	a_no_lane_data: assert property (state == DTR_WAIT_L2 && !trig_def_wr &&
		level_two_global_enable && !level_two_combine_select &&
		level_two_data_lane_enable == '0 && pc_cond_in && addr_cond
		|=> breakpoint_status_out == `DTR_ST_DONE_L2)
		else $error("data lanes disabled yet trigger blocked");

endmodule

// [sim/dtr_bus_model.sv]
// Behavioural local bus: presents one attribute set for one cycle per request.
// Assumes requests change just after the rising clock edge.
`timescale 1ns/1ps

module dtr_bus_model
	import dtr_pkg::*;
(
	input wire logic clk_in,
	input wire logic go_in,
	input wire dtr_attr_t attr_in,
	output logic valid_out,
	output dtr_attr_t attr_out
);
	// Idle lines show the inverse of the old value, so stale attributes never match by luck
	always_ff @(posedge clk_in)
	begin
		valid_out <= go_in;
		attr_out <= go_in ? attr_in : ~attr_out;
	end
endmodule

// [sim/dtr_trigger_tb_top.sv]
// Self-checking bench for the debug trigger block.
// Assumes one 40 MHz clock; bus traffic comes from dtr_bus_model.
`timescale 1ns/1ps

module dtr_trigger_tb_top
	import dtr_pkg::*;
;
	logic clk = 0, rst = 1, cwr = 0, csup = 0, pwr = 0, go = 0, l1 = 0, pc = 0, ar = 0;
	logic [3:0] cnum = 0, pnum = 0, st;
	logic [31:0] cdat = 0, pdat = 0;
	logic [6:0] lanes = 0;
	dtr_attr_t ga = 0, ba;
	logic vld, am, rpt, halt, irq;
	logic [7:0] pma;
	int mismatches = 0, checks = 0;

	always #12.5 clk = ~clk;

	dtr_bus_model i_bus (.clk_in(clk), .go_in(go), .attr_in(ga), .valid_out(vld), .attr_out(ba));

	dtr_trigger i_dut (.core_clk_in(clk), .rst_in(rst), .core_wr_in(cwr), .core_super_in(csup),
		.core_dreg_num_in(cnum), .core_dreg_data_in(cdat), .port_wr_in(pwr),
		.port_dreg_num_in(pnum), .port_dreg_data_in(pdat), .bus_valid_in(vld),
		.bus_rw_in(ba[7]), .bus_size_in(ba[6:5]), .bus_type_in(ba[4:3]),
		.bus_modifier_in(ba[2:0]), .level_one_hit_in(l1), .pc_cond_in(pc),
		.addr_range_in(ar), .data_lane_hit_in(lanes), .attr_match_out(am),
		.breakpoint_status_out(st), .trigger_report_out(rpt), .halt_req_out(halt),
		.debug_irq_out(irq), .port_mem_attr_out(pma));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Port and core strobes never overlap here, so the port priority is not relied on
	task automatic wr(input logic port, input logic sup, input logic [3:0] n, input logic [31:0] d);
		@(posedge clk);
		pwr <= port;
		cwr <= !port;
		csup <= sup;
		pnum <= n;
		cnum <= n;
		pdat <= d;
		cdat <= d;
		@(posedge clk);
		pwr <= 0;
		cwr <= 0;
		#1;
	endtask

	task automatic bus(input dtr_attr_t a);
		@(posedge clk);
		go <= 1;
		ga <= a;
		@(posedge clk);
		go <= 0;
		@(posedge clk);
		#1;
	endtask

	// Conditions sit in the same cycle as the bus transfer
	task automatic fire(input logic h, input logic p, input logic a, input logic [6:0] ln);
		@(posedge clk);
		go <= 1;
		@(posedge clk);
		go <= 0;
		l1 <= h;
		pc <= p;
		ar <= a;
		lanes <= ln;
		@(posedge clk);
		l1 <= 0;
		pc <= 0;
		ar <= 0;
		lanes <= 0;
		#1;
	endtask

	task automatic s_attr();
		dtr_attr_t v;
		chk({am, st, pma}, {1'b0, 4'h0, 8'h05});
		wr(0, 1, 4'h6, 32'hFFFF_0025);
		chk(pma, 8'h25);
		wr(0, 0, 4'h6, 32'h0000_0046);
		wr(1, 0, 4'h5, 32'h0000_0046);
		chk(pma, 8'h25);
		bus(8'h25);
		chk(am, 1);
		bus(8'hA5);
		chk(am, 0);
		bus(8'h45);
		chk(am, 0);
		bus(8'h2D);
		chk(am, 0);
		wr(0, 1, 4'h6, 32'h0000_F825);
		bus(8'hCD);
		chk(am, 1);
		for (int i = 0; i < 4; i++)
		begin
			v = {5'h00, i[0] ? 3'h1 : 3'h2} ^ {5'h00, i[1] ? 3'h7 : 3'h0};
			wr(1, 0, 4'h6, {24'h0, v});
			chk(pma, v);
			bus(v);
			chk(am, 1);
			bus(v ^ 8'h07);
			chk(am, 0);
		end
	endtask

	task automatic s_level2();
		for (int r = 0; r < 4; r++)
		begin
			wr(1, 0, 4'h7, 32'h0);
			chk(st, 0);
			wr(0, 1, 4'h7, {r[1:0], 30'h2000_8000});
			chk(st, 5);
			fire(0, 1, 0, 0);
			chk({st, rpt, halt, irq}, {4'h6, 1'b1, r == 1, r == 2});
			@(posedge clk);
			#1 chk({st, rpt, halt, irq}, {4'h6, 3'b000});
		end
		wr(1, 0, 4'h7, 32'h0000_8000);
		fire(0, 1, 1, 0);
		chk({st, rpt}, 5'h00);
	endtask

	task automatic s_lanes();
		wr(1, 0, 4'h7, 32'h0);
		wr(1, 0, 4'h6, 32'h0000_FF00);
		wr(1, 0, 4'h7, 32'h3000_0000);
		fire(0, 1, 1, 7'h01);
		chk(st, 5);
		fire(0, 1, 0, 7'h40);
		chk(st, 5);
		fire(0, 1, 1, 7'h40);
		chk({st, rpt}, {4'h6, 1'b1});
		wr(1, 0, 4'h7, 32'h2000_0000);
		fire(0, 1, 1, 0);
		chk(st, 6);
	endtask

	task automatic s_level1();
		wr(1, 0, 4'h7, 32'h0000_2000);
		chk(st, 1);
		fire(1, 0, 0, 0);
		chk({st, rpt}, {4'h2, 1'b1});
		wr(1, 0, 4'h7, 32'h2000_A000);
		fire(1, 0, 0, 0);
		chk({st, rpt}, {4'h5, 1'b0});
		fire(0, 1, 0, 0);
		chk(st, 6);
	endtask

	// Mid-run reset after a completed trigger and a fully masked attribute word
	task automatic s_reset();
		@(posedge clk);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		#1 chk({am, st, rpt, halt, irq, pma}, {1'b0, 4'h0, 3'b000, 8'h05});
		bus(8'hA5);
		chk(am, 0);
	endtask

	initial
	begin
		repeat (4000) @(posedge clk);
		mismatches++;
		report_and_stop();
	end

	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		#1;
		s_attr();
		s_level2();
		s_lanes();
		s_reset();
		s_level1();
		report_and_stop();
	end
endmodule
